// ==== ascs_pkg.sv ====
// Constants, field layouts and types shared by the sample/convert sequencer.
package ascs_pkg;
  localparam int SETUP_W = 12;
  localparam int SU_CLK_SRC_BIT = 8;
  localparam int SU_SHORT_BIT = 9;
  localparam int SU_MODE_LSB = 5;
  localparam int SU_SEQ_LSB = 3;
  localparam int SU_PIN_FN_BIT = 2;
  localparam int SU_THR_LSB = 0;
  localparam logic [11:0] SETUP_RESET = 12'h800;
  localparam logic [3:0] CMD_SETUP_WRITE = 4'ha;
  localparam logic [3:0] CMD_FIFO_READ = 4'he;
  localparam logic [5:0] CMD_END = 6'h04;
  localparam logic [5:0] SHORT_END = 6'h10;
  localparam logic [5:0] LONG_END = 6'h30;
  localparam logic [5:0] SETUP_END = 6'h10;
  localparam int RESULT_W = 14;
  localparam int FIFO_DEPTH = 8;
  localparam logic [4:0] CONV_CLOCKS_14B = 5'h12;
  localparam logic [4:0] CONV_CLOCKS_12B = 5'h0d;
  localparam logic [4:0] CONV_CLOCKS = CONV_CLOCKS_14B;
  localparam logic [1:0] SCLK_PER_CONV_CLK = 2'h3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int EDGE_DELAY_NS = 15;
  localparam logic [1:0] EDGE_DELAY_CYC =
    2'((EDGE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] OSC_DIV = 4'h4;
  typedef enum logic [1:0] {
    MODE_ONESHOT = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_SWEEP = 2'b10,
    MODE_RSWEEP = 2'b11
  } ascs_mode_t;
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_CMD = 2'b01,
    FR_SAMPLE = 2'b11,
    FR_DATA = 2'b10
  } ascs_frame_t;
  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_CLOCKS = 2'b01,
    CV_DELAY = 2'b11
  } ascs_conv_t;
endpackage

// ==== ascs_conv_if.sv ====
// Handshake between the sequencer and its conversion timer.
`timescale 1ns/10ps
interface ascs_conv_if;
  logic start;
  logic sclk_rise;
  logic use_sclk;
  logic busy;
  logic done;
  modport ctl (output start, output sclk_rise, output use_sclk, input busy, input done);
  modport tmr (input start, input sclk_rise, input use_sclk, output busy, output done);
endinterface

// ==== ascs_conv_timer.sv ====
// Conversion period timer with on-chip or serial-clock-derived conversion clock.
`timescale 1ns/10ps
module ascs_conv_timer (
  input wire logic mclk,
  input wire logic srst,
  ascs_conv_if.tmr cv
);
  import ascs_pkg::*;

  ascs_conv_t state_ff;
  logic [3:0] osc_div_ff;
  logic [1:0] sclk_div_ff;
  logic [4:0] clk_cnt_ff;
  logic [1:0] dly_ff;
  logic busy_ff;
  logic done_ff;

  wire osc_tick = (osc_div_ff == OSC_DIV - 4'h1);
  wire sclk_tick = cv.sclk_rise && (sclk_div_ff == SCLK_PER_CONV_CLK);
  wire conv_tick = cv.use_sclk ? sclk_tick : osc_tick;

  assign cv.busy = busy_ff;
  assign cv.done = done_ff;

  // The oscillator runs free; the serial divider restarts with each conversion.
  always_ff @(posedge mclk) begin
    if (srst || osc_tick) begin
      osc_div_ff <= 4'h0;
    end else begin
      osc_div_ff <= osc_div_ff + 4'h1;
    end
  end

  // A new start aborts a conversion in progress, as the converter itself would.
  always_ff @(posedge mclk) begin
    done_ff <= 1'b0;
    if (srst) begin
      state_ff <= CV_IDLE;
      sclk_div_ff <= 2'h0;
      clk_cnt_ff <= 5'h0;
      dly_ff <= 2'h0;
      busy_ff <= 1'b0;
    end else if (cv.start) begin
      state_ff <= CV_CLOCKS;
      sclk_div_ff <= 2'h0;
      clk_cnt_ff <= 5'h0;
      busy_ff <= 1'b1;
    end else begin
      if (cv.sclk_rise) begin
        sclk_div_ff <= sclk_div_ff + 2'h1;
      end
      unique case (state_ff)
        CV_IDLE: begin
          busy_ff <= 1'b0;
        end
        CV_CLOCKS: begin
          if (conv_tick) begin
            clk_cnt_ff <= clk_cnt_ff + 5'h1;
            if (clk_cnt_ff == CONV_CLOCKS - 5'h1) begin
              state_ff <= CV_DELAY;
              dly_ff <= EDGE_DELAY_CYC;
            end
          end
        end
        CV_DELAY: begin
          dly_ff <= dly_ff - 2'h1;
          if (dly_ff == 2'h1) begin
            state_ff <= CV_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= CV_IDLE;
        end
      endcase
    end
  end
endmodule // ascs_conv_timer

// ==== ascs_sequencer.sv ====
// Sampling and conversion sequencer of a serial multichannel converter.
// Summary of operation
// - Two-bit mode: one-shot, repeat, sweep, repeat-sweep.
// - Setup bit picks interrupt or end-of-conversion pin in one-shot mode.
// - Threshold code sets FIFO fill and sweep length.
// - Short sampling lasts 12 serial clocks, then converts.
// - Normal sampling starts after fourth serial clock fall.
// - Long sampling lasts 44 serial clocks.
// - Strobe low samples; rising edge starts conversion after delay.
// - Leave extended mode after two frame starts.
// - Extended mode needs no serial clock with oscillator.
// - Conversion starts after clock 16, 48, or strobe.
// - Conversion lasts 18 clocks plus delay.
// - Conversion clock: oscillator cycle or four serial clocks.
// - End flag low during conversion; interrupt low after.
// - One-shot converts once; result shifts out next frame.
// - Repeat fills FIFO to threshold, interrupts, ends.
// - Unread repeat results are overwritten next operation.
// - Select commands during repeat are dummies for channel.
// - Strobe-triggered repeat may restart immediately when full.
// - Sweep converts each sequence channel in order.
// - Setup bit chooses oscillator or serial clock quarter.
// - Setup bit chooses long or short sampling.
`timescale 1ns/10ps
module ascs_sequencer (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic frame_sync_strobe,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic conversion_start_strobe_n,
  input wire logic [ascs_pkg::RESULT_W-1:0] adc_result,
  output logic sdo,
  output logic sdo_oe,
  output logic status_n,
  output logic sampling,
  output logic converting,
  output logic [2:0] channel
);
  import ascs_pkg::*;

  ascs_conv_if cv ();

  // Fill count for each threshold code.
  function automatic logic [3:0] thr_count(input logic [1:0] code);
    return 4'h8 - {1'b0, code, 1'b0};
  endfunction

  // Channel at position idx of the eight-step sweep sequence seq.
  function automatic logic [2:0] sweep_chan(input logic [1:0] seq, input logic [2:0] idx);
    unique case (seq)
      2'b00: return idx;
      2'b01: return {idx[1:0], 1'b0};
      2'b10: return {idx[2:1], 1'b0};
      default: return {1'b0, idx[0], 1'b0};
    endcase
  endfunction

  logic cs_prev_ff, fs_prev_ff, sclk_prev_ff, cst_prev_ff;
  ascs_frame_t frame_ff;
  logic [5:0] bit_cnt_ff;
  logic [15:0] shift_in_ff;
  logic [15:0] out_sr_ff;
  logic [SETUP_W-1:0] setup_ff;
  logic [RESULT_W-1:0] result_ff;
  logic [RESULT_W-1:0] fifo_ff [FIFO_DEPTH];
  logic [3:0] wr_cnt_ff;
  logic [2:0] rd_ptr_ff;
  logic rd_adv_ff;
  logic op_active_ff;
  logic wait_read_ff;
  logic ext_ff;
  logic ext_exit_ff;
  logic [1:0] ext_dly_ff;
  logic int_n_ff;
  logic sdo_ff, sdo_oe_ff, status_ff, sampling_ff, converting_ff;
  logic [2:0] channel_ff;
  logic start_ff;

  wire frame_start = (cs_prev_ff && !cs_n) || (!fs_prev_ff && frame_sync_strobe);
  wire cs_rise = !cs_prev_ff && cs_n;
  wire sclk_fall = sclk_prev_ff && !sclk;
  wire sclk_rise = !sclk_prev_ff && sclk;
  wire cst_fall = cst_prev_ff && !conversion_start_strobe_n;
  wire cst_rise = !cst_prev_ff && conversion_start_strobe_n;
  wire [15:0] nxt_shift = {shift_in_ff[14:0], sdi};
  wire [5:0] nxt_bit_cnt = bit_cnt_ff + 6'h1;
  wire [3:0] cmd = nxt_shift[3:0];
  wire cmd_is_select = !cmd[3];
  ascs_mode_t mode;
  assign mode = ascs_mode_t'(setup_ff[SU_MODE_LSB +: 2]);
  wire mode_oneshot = (mode == MODE_ONESHOT);
  wire mode_sweep = setup_ff[SU_MODE_LSB + 1];
  wire pin_is_eoc = setup_ff[SU_PIN_FN_BIT] && mode_oneshot;
  wire [3:0] fill_target = thr_count(setup_ff[SU_THR_LSB +: 2]);
  wire [5:0] sample_end = setup_ff[SU_SHORT_BIT] ? SHORT_END : LONG_END;
  wire cmd_edge = sclk_fall && (frame_ff == FR_CMD) && (nxt_bit_cnt == CMD_END);
  wire sample_done = sclk_fall && (frame_ff == FR_SAMPLE) && (nxt_bit_cnt == sample_end);
  wire setup_edge = sclk_fall && (frame_ff == FR_DATA) && (nxt_bit_cnt == SETUP_END);
  wire setup_cmd = (nxt_shift[15:12] == CMD_SETUP_WRITE);
  wire trig_ok = !wait_read_ff;
  wire ext_go = (ext_dly_ff == 2'h1);
  wire conv_begin = sample_done || ext_go;
  wire [2:0] seq_chan = sweep_chan(setup_ff[SU_SEQ_LSB +: 2], wr_cnt_ff[2:0]);
  wire fill_hit = cv.done && !mode_oneshot && (wr_cnt_ff + 4'h1 == fill_target);
  wire [RESULT_W-1:0] out_word = mode_oneshot ? result_ff : fifo_ff[rd_ptr_ff];

  assign cv.start = start_ff;
  assign cv.sclk_rise = sclk_rise;
  assign cv.use_sclk = setup_ff[SU_CLK_SRC_BIT];

  assign sdo = sdo_ff;
  assign sdo_oe = sdo_oe_ff;
  assign status_n = status_ff;
  assign sampling = sampling_ff;
  assign converting = converting_ff;
  assign channel = channel_ff;

  ascs_conv_timer u_timer (
    .mclk(mclk),
    .srst(srst),
    .cv(cv)
  );

  always_ff @(posedge mclk) begin
    if (srst) begin
      cs_prev_ff <= 1'b1;
      fs_prev_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
      cst_prev_ff <= 1'b1;
    end else begin
      cs_prev_ff <= cs_n;
      fs_prev_ff <= frame_sync_strobe;
      sclk_prev_ff <= sclk;
      cst_prev_ff <= conversion_start_strobe_n;
    end
  end

  // Frame decoder: command nibble, then sampling window or setup data.
  always_ff @(posedge mclk) begin
    if (srst) begin
      frame_ff <= FR_IDLE;
      bit_cnt_ff <= 6'h0;
      shift_in_ff <= 16'h0;
    end else if (frame_start) begin
      frame_ff <= FR_CMD;
      bit_cnt_ff <= 6'h0;
      shift_in_ff <= 16'h0;
    end else if (cs_rise) begin
      frame_ff <= FR_IDLE;
    end else if (sclk_fall && frame_ff != FR_IDLE) begin
      shift_in_ff <= nxt_shift;
      if (bit_cnt_ff != 6'h3f) begin
        bit_cnt_ff <= nxt_bit_cnt;
      end
      if (cmd_edge) begin
        // In extended mode a select frame only talks; it never samples.
        frame_ff <= (cmd_is_select && !ext_ff && trig_ok) ? FR_SAMPLE : FR_DATA;
      end else if (sample_done || setup_edge) begin
        frame_ff <= FR_DATA;
      end
    end
  end

  // Setup register; a write also abandons any operation in progress.
  always_ff @(posedge mclk) begin
    if (srst) begin
      setup_ff <= SETUP_RESET;
    end else if (setup_edge && setup_cmd) begin
      setup_ff <= nxt_shift[SETUP_W-1:0];
    end
  end

  // Sampling window and conversion start, from serial count or strobe.
  always_ff @(posedge mclk) begin
    start_ff <= 1'b0;
    if (srst) begin
      sampling_ff <= 1'b0;
      ext_dly_ff <= 2'h0;
    end else begin
      if (ext_dly_ff != 2'h0) begin
        ext_dly_ff <= ext_dly_ff - 2'h1;
      end
      if (cst_fall && trig_ok) begin
        sampling_ff <= 1'b1;
      end else if (cst_rise && ext_ff && sampling_ff) begin
        sampling_ff <= 1'b0;
        ext_dly_ff <= EDGE_DELAY_CYC + 2'h1;
      end else if (cmd_edge && cmd_is_select && !ext_ff && trig_ok) begin
        sampling_ff <= 1'b1;
      end else if (sample_done) begin
        sampling_ff <= 1'b0;
      end
      if (conv_begin) begin
        start_ff <= 1'b1;
      end
    end
  end

  // Extended mode entry on strobe fall; exit after two frame starts.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ext_ff <= 1'b0;
      ext_exit_ff <= 1'b0;
    end else if (cst_fall && trig_ok) begin
      ext_ff <= 1'b1;
      ext_exit_ff <= 1'b0;
    end else if (frame_start && ext_ff && conversion_start_strobe_n) begin
      ext_exit_ff <= !ext_exit_ff;
      if (ext_exit_ff) begin
        ext_ff <= 1'b0;
      end
    end
  end

  // Channel choice: locked while an operation runs, or walked by sweep.
  always_ff @(posedge mclk) begin
    if (srst) begin
      channel_ff <= 3'h0;
    end else if (mode_sweep) begin
      channel_ff <= seq_chan;
    end else if (cmd_edge && cmd_is_select && !op_active_ff) begin
      channel_ff <= cmd[2:0];
    end
  end

  // Result capture into the one-shot latch or the FIFO.
  always_ff @(posedge mclk) begin
    if (srst) begin
      result_ff <= '0;
      wr_cnt_ff <= 4'h0;
      op_active_ff <= 1'b0;
      wait_read_ff <= 1'b0;
    end else if (setup_edge && setup_cmd) begin
      wr_cnt_ff <= 4'h0;
      op_active_ff <= 1'b0;
      wait_read_ff <= 1'b0;
    end else begin
      if (cmd_edge && cmd == CMD_FIFO_READ) begin
        wait_read_ff <= 1'b0;
      end
      if (start_ff && !mode_oneshot && !op_active_ff) begin
        op_active_ff <= 1'b1;
        wr_cnt_ff <= 4'h0;
      end
      if (cv.done) begin
        if (mode_oneshot) begin
          result_ff <= adc_result;
        end else if (fill_hit) begin
          op_active_ff <= 1'b0;
          wr_cnt_ff <= 4'h0;
          wait_read_ff <= (mode == MODE_SWEEP);
        end else begin
          wr_cnt_ff <= wr_cnt_ff + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (cv.done && !mode_oneshot) begin
      fifo_ff[wr_cnt_ff[2:0]] <= adc_result;
    end
  end

  // FIFO read pointer steps once per completed read frame.
  always_ff @(posedge mclk) begin
    if (srst || fill_hit) begin
      rd_ptr_ff <= 3'h0;
      rd_adv_ff <= 1'b0;
    end else if (cmd_edge) begin
      rd_adv_ff <= (cmd == CMD_FIFO_READ);
    end else if ((cs_rise || frame_start) && rd_adv_ff) begin
      rd_ptr_ff <= rd_ptr_ff + 3'h1;
      rd_adv_ff <= 1'b0;
    end
  end

  // Serial output: the stored word shifts out MSB first from frame start.
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_sr_ff <= 16'h0;
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else begin
      sdo_oe_ff <= !cs_n && (frame_ff != FR_IDLE || frame_start);
      if (frame_start) begin
        out_sr_ff <= {out_word, 2'b00};
        sdo_ff <= out_word[RESULT_W-1];
      end else if (sclk_fall) begin
        out_sr_ff <= {out_sr_ff[14:0], 1'b0};
        sdo_ff <= out_sr_ff[14];
      end
    end
  end

  // Shared status pin: end-of-conversion level or completion interrupt.
  always_ff @(posedge mclk) begin
    if (srst) begin
      int_n_ff <= 1'b1;
      status_ff <= 1'b1;
      converting_ff <= 1'b0;
    end else begin
      converting_ff <= cv.busy;
      if ((cv.done && mode_oneshot) || fill_hit) begin
        int_n_ff <= 1'b0;
      end else if (frame_start || cst_fall) begin
        int_n_ff <= 1'b1;
      end
      if (pin_is_eoc) begin
        status_ff <= !(cv.busy || start_ff);
      end else if ((cv.done && mode_oneshot) || fill_hit) begin
        status_ff <= 1'b0;
      end else begin
        status_ff <= int_n_ff;
      end
    end
  end
endmodule // ascs_sequencer

// ==== ascs_sequencer_chk.sv ====
// Port-level property checker for the sample/convert sequencer.
`timescale 1ns/10ps
module ascs_sequencer_chk (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic frame_sync_strobe,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic conversion_start_strobe_n,
  input wire logic [ascs_pkg::RESULT_W-1:0] adc_result,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic status_n,
  input wire logic sampling,
  input wire logic converting,
  input wire logic [2:0] channel
);
  import ascs_pkg::*;
  logic sclk_q_ff;
  logic [5:0] fall_cnt_ff;
  logic [9:0] conv_len_ff;
  logic [2:0] recent_ff;
  wire sclk_fall = sclk_q_ff && !sclk;
  wire [5:0] nxt_fall_cnt = !sampling ? 6'h00 : (sclk_fall ? fall_cnt_ff + 6'h01 : fall_cnt_ff);
  wire [9:0] nxt_conv_len = !converting ? 10'h000 :
    ((conv_len_ff == 10'h3ff) ? conv_len_ff : conv_len_ff + 10'h001);
  // Keeps the last few cycles of a conversion visible, since the pin may lead or lag it.
  wire [2:0] nxt_recent = converting ? 3'h7 : ((recent_ff != 3'h0) ? recent_ff - 3'h1 : 3'h0);
  always_ff @(posedge mclk) begin
    sclk_q_ff <= srst ? 1'b0 : sclk;
    fall_cnt_ff <= srst ? 6'h00 : nxt_fall_cnt;
    conv_len_ff <= srst ? 10'h000 : nxt_conv_len;
    recent_ff <= srst ? 3'h0 : nxt_recent;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_strobe_low;
    !conversion_start_strobe_n [*5];
  endsequence
  sequence s_normal_end;
    $fell(sampling) ##0 $past(conversion_start_strobe_n, 4);
  endsequence
  property p_norm_len;
    s_normal_end |-> (fall_cnt_ff == 6'h0c || fall_cnt_ff == 6'h2c);
  endproperty
  a_norm_len: assert property (p_norm_len) else $error("sampling window length wrong");
  property p_conv_follows;
    $fell(sampling) |-> ##[1:5] converting;
  endproperty
  a_conv_follows: assert property (p_conv_follows) else $error("no conversion after sampling");
  property p_conv_min;
    $rose(converting) |=> converting [*8];
  endproperty
  a_conv_min: assert property (p_conv_min) else $error("conversion too short");
  property p_conv_bound;
    $rose(converting) |-> ##[1:1000] !converting;
  endproperty
  a_conv_bound: assert property (p_conv_bound) else $error("conversion never ends");
  property p_conv_len;
    $fell(converting) |-> (conv_len_ff inside {[10'h042:10'h050], [10'h33e:10'h384]});
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_status_conv;
    $fell(status_n) |-> ##[0:3] (recent_ff != 3'h0);
  endproperty
  a_status_conv: assert property (p_status_conv) else $error("status pin unrelated");
  property p_oe_on;
    $fell(cs_n) |-> ##[1:2] sdo_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not enabled");
  property p_oe_off;
    $rose(cs_n) |-> ##[1:2] !sdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output not released");
  property p_strobe_start;
    $fell(conversion_start_strobe_n) |-> ##[1:3] sampling;
  endproperty
  a_strobe_start: assert property (p_strobe_start) else $error("strobe did not sample");
  property p_strobe_hold;
    s_strobe_low |-> sampling;
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("sampling dropped");
  property p_strobe_stop;
    $rose(conversion_start_strobe_n) |-> ##[1:3] !sampling;
  endproperty
  a_strobe_stop: assert property (p_strobe_stop) else $error("sampling kept");
endmodule // ascs_sequencer_chk
bind ascs_sequencer ascs_sequencer_chk i_chk (.mclk(mclk), .srst(srst), .cs_n(cs_n),
  .frame_sync_strobe(frame_sync_strobe), .sclk(sclk), .sdi(sdi),
  .conversion_start_strobe_n(conversion_start_strobe_n), .adc_result(adc_result),
  .sdo(sdo), .sdo_oe(sdo_oe), .status_n(status_n), .sampling(sampling),
  .converting(converting), .channel(channel));

// ==== ascs_host_model.sv ====
// Host serial port model driving select frames, serial clock and strobe.
`timescale 1ns/10ps
module ascs_host_model #(
  parameter int SCLK_HALF = 6
) (
  input wire logic mclk,
  output logic cs_n,
  output logic frame_sync_strobe,
  output logic sclk,
  output logic sdi,
  output logic conversion_start_strobe_n,
  input wire logic sdo
);
  logic [15:0] rx_word;
  initial begin
    cs_n = 1'b1;
    frame_sync_strobe = 1'b0;
    sclk = 1'b0;
    sdi = 1'b0;
    conversion_start_strobe_n = 1'b1;
    rx_word = 16'h0000;
  end
  // Only select starts frames, so trigger kinds are never mixed.
  task automatic frame(input logic [15:0] word, input int nclk);
    @(posedge mclk);
    cs_n <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < nclk; i++) begin
      sdi <= (i < 16) ? word[15 - i] : ~sdi;
      sclk <= 1'b1;
      repeat (SCLK_HALF) @(posedge mclk);
      if (i < 16) rx_word[15 - i] = sdo;
      sclk <= 1'b0;
      repeat (SCLK_HALF) @(posedge mclk);
    end
    cs_n <= 1'b1;
    sdi <= ~sdi;
  endtask
  // Same period as inside a frame, so serial conversion clocks keep their nominal length.
  task automatic run_sclk(input int n);
    repeat (n) begin
      sclk <= 1'b1;
      repeat (SCLK_HALF) @(posedge mclk);
      sclk <= 1'b0;
      repeat (SCLK_HALF) @(posedge mclk);
    end
  endtask
  // Called only after a whole frame, well past its eleventh clock.
  task automatic strobe(input int low);
    @(posedge mclk);
    conversion_start_strobe_n <= 1'b0;
    repeat (low) @(posedge mclk);
    conversion_start_strobe_n <= 1'b1;
  endtask
endmodule // ascs_host_model

// ==== tb_top.sv ====
// Self-checking testbench for the sample/convert sequencer.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  import ascs_pkg::*;
  localparam int HALF = 6;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cs_n, frame_sync_strobe, sclk, sdi, conversion_start_strobe_n;
  logic [RESULT_W-1:0] adc_result = '0;
  logic sdo, sdo_oe, status_n, sampling, converting, samp_q, conv_q;
  logic [2:0] channel, ch;
  logic [1:0] seq;
  logic [13:0] res;
  logic [2:0] ch_q[$];
  int fails = 0, check_count = 0, seed = 44151;
  int samp_len, conv_len, samp_run, conv_run, n;
  bit samp_seen;
  always #5 mclk = ~mclk;
  ascs_sequencer i_dut (.mclk(mclk), .srst(srst), .cs_n(cs_n),
    .frame_sync_strobe(frame_sync_strobe), .sclk(sclk), .sdi(sdi),
    .conversion_start_strobe_n(conversion_start_strobe_n), .adc_result(adc_result),
    .sdo(sdo), .sdo_oe(sdo_oe), .status_n(status_n), .sampling(sampling),
    .converting(converting), .channel(channel));
  ascs_host_model #(.SCLK_HALF(HALF)) i_host (.mclk(mclk), .cs_n(cs_n),
    .frame_sync_strobe(frame_sync_strobe), .sclk(sclk), .sdi(sdi),
    .conversion_start_strobe_n(conversion_start_strobe_n), .sdo(sdo));
  always @(posedge mclk) begin
    samp_q <= sampling;
    conv_q <= converting;
    samp_run <= sampling ? samp_run + 1 : 0;
    conv_run <= converting ? conv_run + 1 : 0;
    if (sampling === 1'b1) samp_seen <= 1'b1;
    if (samp_q && !sampling) begin
      samp_len <= samp_run;
      ch_q.push_back(channel);
    end
    if (conv_q && !converting) conv_len <= conv_run;
  end
  function automatic int thr_count(input logic [1:0] code);
    return 8 - 2 * code;
  endfunction
  function automatic logic [2:0] seq_ch(input logic [1:0] sq, input int i);
    case (sq)
      2'h0: return 3'(i);
      2'h1: return 3'((i * 2) % 8);
      2'h2: return 3'((i / 2) * 2);
      default: return 3'((i % 2) * 2);
    endcase
  endfunction
  function automatic bit conv_ok(input int len, input bit ser);
    int nom;
    int tol;
    nom = int'(CONV_CLOCKS) * (ser ? 8 * HALF : int'(OSC_DIV));
    tol = ser ? 4 * HALF : int'(OSC_DIV) + 4;
    return (len >= nom - tol) && (len <= nom + tol);
  endfunction
  task automatic report_and_stop;
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A lapsed wait shows up as a failed compare instead of a hang.
  task automatic wait_cv(input logic lvl);
    for (int i = 0; i < 2000 && converting !== lvl; i++) @(posedge mclk);
    `CHK("conversion wait", lvl, converting)
    repeat (2) @(posedge mclk);
  endtask
  task automatic setup(input logic [1:0] md, input logic [1:0] sq, input logic pin,
                       input logic [1:0] thr, input logic shrt, input logic ser);
    logic [11:0] w;
    w = 12'h800;
    w[SU_MODE_LSB +: 2] = md;
    w[SU_SEQ_LSB +: 2] = sq;
    w[SU_PIN_FN_BIT] = pin;
    w[SU_THR_LSB +: 2] = thr;
    w[SU_SHORT_BIT] = shrt;
    w[SU_CLK_SRC_BIT] = ser;
    i_host.frame({CMD_SETUP_WRITE, w}, 16);
    repeat (4) @(posedge mclk);
  endtask
  task automatic convert(input logic [2:0] c);
    i_host.frame({1'b0, c, 12'h000}, 16);
    wait_cv(1'b1);
    wait_cv(1'b0);
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    ch = 3'($random(seed));
    i_host.frame({1'b0, ch, 12'h000}, 48);
    wait_cv(1'b1);
    wait_cv(1'b0);
    `CHK("long sampling", 44, (samp_len + HALF) / (2 * HALF))
    `CHK("channel", ch, channel)
    `CHK("interrupt pin", 1'b0, status_n)
    setup(MODE_ONESHOT, 2'h0, 1'b1, 2'h0, 1'b1, 1'b0);
    res = 14'($random(seed));
    adc_result <= res;
    i_host.frame({1'b0, ch, 12'h000}, 16);
    wait_cv(1'b1);
    repeat (8) @(posedge mclk);
    `CHK("eoc during", 1'b0, status_n)
    wait_cv(1'b0);
    `CHK("eoc after", 1'b1, status_n)
    `CHK("short sampling", 12, (samp_len + HALF) / (2 * HALF))
    `CHK("osc conversion", 1'b1, conv_ok(conv_len, 1'b0))
    adc_result <= 14'($random(seed));
    convert(ch);
    `CHK("result word", {res, 2'b00}, i_host.rx_word)
    fork
      i_host.strobe(20);
      begin
        repeat (12) @(posedge mclk);
        `CHK("strobe sampling", 1'b1, sampling)
      end
    join
    wait_cv(1'b1);
    wait_cv(1'b0);
    `CHK("strobe window", 20, samp_len)
    samp_seen = 1'b0;
    i_host.frame({1'b0, ch, 12'h000}, 16);
    repeat (20) @(posedge mclk);
    `CHK("exit first frame", 1'b0, samp_seen)
    convert(ch);
    `CHK("exit second frame", 1'b1, samp_seen)
    setup(MODE_ONESHOT, 2'h0, 1'b0, 2'h0, 1'b1, 1'b1);
    i_host.frame({1'b0, ch, 12'h000}, 16);
    i_host.run_sclk(90);
    `CHK("sclk conversion", 1'b1, conv_ok(conv_len, 1'b1))
    for (int k = 0; k < 4; k++) begin
      seq = 2'($random(seed));
      setup(MODE_REPEAT, seq, 1'b0, 2'(k), 1'b1, 1'b0);
      ch = 3'($random(seed));
      ch_q.delete();
      n = 0;
      do begin
        convert((n == 0) ? ch : 3'($random(seed)));
        n++;
      end while (status_n !== 1'b0 && n < 10);
      `CHK("repeat count", thr_count(2'(k)), n)
      foreach (ch_q[q]) `CHK("repeat channel", ch, ch_q[q])
    end
    for (int m = 2; m < 4; m++) begin
      seq = 2'($random(seed));
      setup(2'(m), seq, 1'b0, 2'h0, 1'b1, 1'b0);
      ch_q.delete();
      repeat (8) convert(3'($random(seed)));
      `CHK("sweep interrupt", 1'b0, status_n)
      foreach (ch_q[q]) `CHK("sweep channel", seq_ch(seq, q), ch_q[q])
      if (m == 2) begin
        samp_seen = 1'b0;
        i_host.frame({1'b0, ch, 12'h000}, 16);
        repeat (20) @(posedge mclk);
        `CHK("sweep held", 1'b0, samp_seen)
        i_host.frame({CMD_FIFO_READ, 12'h000}, 16);
        `CHK("fifo word", {adc_result, 2'b00}, i_host.rx_word)
      end
    end
    report_and_stop();
  end
endmodule // tb_top
